// *** verilog/pds_sequencer.sv ***
// Press and shear dwell sequencer with encoder length counter and Wishbone registers
// What this block does
// - Shear down held 1 ms to 30 s
// - Shear up output held 0 to 30 s
// - Shear completion ends down dwell at once
// - Up dwell ignores the down completion input
// - Missing down completion: leave run, abort, fault
// - Up completion input ends up dwell early
// - Missing up completion: up dwell runs out, leave run, fault
// - Expecting up completion blocks run entry when off
// - Each press has its own dwell copy
// - Press down dwell, cut short by completion
// - Press up dwell 0-30 s after down
// - Missing press completion: leave run, abort, fault
// - Press up completion ends press up dwell
// - Missing press up completion: leave run, fault
// - Press up expectation blocks run entry when off
// - Quadrature edges times resolution gives length
//
// Decided for this implementation: the address map and the Wishbone slave port.
module pds_sequencer #(
  parameter int NCH = 3,
  parameter int TICK_CYCLES = pds_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [NCH-1:0] FIRE,
  input wire logic [NCH-1:0] CMP_DN,
  input wire logic [NCH-1:0] CMP_UP,
  input wire logic ENC_A,
  input wire logic ENC_B,
  output logic [NCH-1:0] OUT_DN,
  output logic [NCH-1:0] OUT_UP,
  output logic RUN,
  output logic IRQ
);

  // Elaboration check: interrupt layout holds eight channels, sub counter 20 bits
  if (NCH < 1 || NCH > 8 || TICK_CYCLES < 1 || TICK_CYCLES > 1048575) begin : g_bad
    $error("pds_sequencer: NCH must be 1..8 and TICK_CYCLES 1..1048575");
  end

  // Bus decode
  wire bus_req = CYC_I & STB_I; // Request present
  wire wr_now = bus_req & WE_I & ACK_O & (SEL_I == 4'hF); // Write lands at the ack edge
  wire [3:0] blk_idx = ADR_I[7:4]; // 16-byte block index
  wire [1:0] word_idx = ADR_I[3:2]; // Word inside a channel block
  wire wr_ctrl = wr_now & (ADR_I == pds_pkg::OFS_CTRL);
  wire wr_istat = wr_now & (ADR_I == pds_pkg::OFS_INT_STAT);
  wire wr_imask = wr_now & (ADR_I == pds_pkg::OFS_INT_MASK);
  wire wr_resol = wr_now & (ADR_I == pds_pkg::OFS_RESOL);
  wire wr_enc_cnt = wr_now & (ADR_I == pds_pkg::OFS_ENC_CNT);

  // Register state
  logic [31:0] int_stat; // Sticky events
  logic [31:0] int_mask; // Enables for IRQ
  logic [31:0] resol; // Length per quadrature edge
  logic [31:0] length; // Accumulated length
  logic [31:0] edges; // Signed edge count
  logic [29:0] enc_cnt; // Encoder rated counts per channel revolution
  logic [1:0] enc_prev; // Last sampled quadrature pair

  // Per channel state and settings
  pds_pkg::pds_state_t st [NCH];
  logic [14:0] dwell_dn [NCH];
  logic [14:0] dwell_up [NCH];
  logic [NCH-1:0] exp_dn; // Expect down completion
  logic [NCH-1:0] exp_up; // Expect up completion
  logic [NCH-1:0] fire_prev; // Fire pin edge detect
  logic [NCH-1:0] fault_dn; // Down supervision failed this cycle
  logic [NCH-1:0] fault_up; // Up supervision failed this cycle
  logic [NCH-1:0] done_ev; // Cycle finished normally this cycle
  logic [NCH-1:0] up_block; // Channel forbids run entry
  logic [31:0] ch_rd [NCH]; // Per channel read value
  logic [NCH-1:0] ch_hit; // Address falls in channel block
  logic [31:0] ev_set; // Events to set this cycle

  // Clamp a written dwell into its allowed range
  function automatic logic [14:0] clamp(input logic [31:0] v, input logic [14:0] lo);
    logic [14:0] r;
    r = lo;
    if (v > {17'h0_0000, pds_pkg::DWELL_MAX}) begin
      r = pds_pkg::DWELL_MAX;
    end else if (v[14:0] > lo) begin
      r = v[14:0];
    end
    return r;
  endfunction

  // One sequencer per channel: index 0 is the shear, the rest are presses
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [19:0] sub; // Cycles within the current ms
    logic [14:0] ms_left; // Whole ms left in the phase
    pds_pkg::pds_state_t next_st;
    wire sel = (blk_idx == pds_pkg::CH_BASE_IDX + 4'(i));
    wire wr_ch = wr_now & sel;
    wire ms_end = (sub == 20'(TICK_CYCLES - 1));
    wire timeout = ms_end & (ms_left == 15'h0001);
    wire sw_fire = wr_ch & (word_idx == pds_pkg::CH_CFG) & DAT_I[pds_pkg::CFG_FIRE];
    wire start = (st[i] == pds_pkg::PDS_IDLE) & (sw_fire | (FIRE[i] & ~fire_prev[i]));
    wire up_skip = (dwell_up[i] == 15'h0000);
    wire f_dn = (st[i] == pds_pkg::PDS_DOWN) & ~CMP_DN[i] & timeout & exp_dn[i];
    wire f_up = (st[i] == pds_pkg::PDS_UP) & ~CMP_UP[i] & timeout & exp_up[i];
    assign ch_hit[i] = sel;
    assign up_block[i] = exp_up[i] & ~CMP_UP[i];
    assign fault_dn[i] = f_dn;
    assign fault_up[i] = f_up;
    assign done_ev[i] = (next_st == pds_pkg::PDS_IDLE) & (st[i] != pds_pkg::PDS_IDLE) &
                        ~f_dn & ~f_up;
    assign ch_rd[i] = (word_idx == pds_pkg::CH_DWELL_DN) ? {17'h0_0000, dwell_dn[i]} :
                      (word_idx == pds_pkg::CH_DWELL_UP) ? {17'h0_0000, dwell_up[i]} :
                      (word_idx == pds_pkg::CH_CFG) ? {30'h0000_0000, exp_up[i], exp_dn[i]} :
                      {28'h000_0000, CMP_UP[i], CMP_DN[i], st[i]};

    // Next phase of the dwell sequence
    always_comb begin
      next_st = st[i];
      case (st[i])
        pds_pkg::PDS_IDLE: begin
          if (start) begin
            next_st = pds_pkg::PDS_DOWN;
          end
        end
        pds_pkg::PDS_DOWN: begin
          if (f_dn) begin
            next_st = pds_pkg::PDS_IDLE;
          end else if (CMP_DN[i] | timeout) begin
            // Completion closes the down phase at once
            next_st = up_skip ? pds_pkg::PDS_IDLE : pds_pkg::PDS_UP;
          end
        end
        pds_pkg::PDS_UP: begin
          // Only the up completion and the timer end this phase
          if (CMP_UP[i] | timeout) begin
            next_st = pds_pkg::PDS_IDLE;
          end
        end
        default: next_st = pds_pkg::PDS_IDLE;
      endcase
    end

    // State, phase timer and registered solenoid outputs
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        st[i] <= pds_pkg::PDS_IDLE;
        sub <= 20'h0_0000;
        ms_left <= 15'h0000;
        OUT_DN[i] <= 1'b0;
        OUT_UP[i] <= 1'b0;
        fire_prev[i] <= 1'b0;
      end else begin
        st[i] <= next_st;
        fire_prev[i] <= FIRE[i];
        OUT_DN[i] <= (next_st == pds_pkg::PDS_DOWN);
        OUT_UP[i] <= (next_st == pds_pkg::PDS_UP);
        if (next_st != st[i]) begin
          // Each phase times from its own first cycle
          sub <= 20'h0_0000;
          ms_left <= (next_st == pds_pkg::PDS_DOWN) ? dwell_dn[i] : dwell_up[i];
        end else if (ms_end) begin
          sub <= 20'h0_0000;
          ms_left <= ms_left - 15'h0001;
        end else begin
          sub <= sub + 20'h0_0001;
        end
      end
    end

    // Channel settings; a dwell write during a cycle applies from the next phase, expect bits at once
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        dwell_dn[i] <= pds_pkg::DWELL_RST;
        dwell_up[i] <= pds_pkg::DWELL_RST;
        exp_dn[i] <= 1'b0;
        exp_up[i] <= 1'b0;
      end else if (wr_ch && word_idx == pds_pkg::CH_DWELL_DN) begin
        dwell_dn[i] <= clamp(DAT_I, pds_pkg::DWELL_DN_MIN);
      end else if (wr_ch && word_idx == pds_pkg::CH_DWELL_UP) begin
        dwell_up[i] <= clamp(DAT_I, pds_pkg::DWELL_UP_MIN);
      end else if (wr_ch && word_idx == pds_pkg::CH_CFG) begin
        exp_dn[i] <= DAT_I[pds_pkg::CFG_EXP_DN];
        exp_up[i] <= DAT_I[pds_pkg::CFG_EXP_UP];
      end
    end

    // Place this channel's events in the interrupt layout
    assign ev_set[i*pds_pkg::EV_PER_CH + pds_pkg::EV_FAULT_DN] = f_dn;
    assign ev_set[i*pds_pkg::EV_PER_CH + pds_pkg::EV_FAULT_UP] = f_up;
    assign ev_set[i*pds_pkg::EV_PER_CH + pds_pkg::EV_DONE] = done_ev[i];
  end

  // Unused event positions stay zero
  for (genvar k = NCH * pds_pkg::EV_PER_CH; k < 32; k++) begin : g_ev_pad
    if (k != pds_pkg::EV_REFUSED) begin : g_zero
      assign ev_set[k] = 1'b0;
    end
  end

  // Run mode control
  wire any_fault = |{fault_dn, fault_up};
  wire run_req = wr_ctrl & DAT_I[pds_pkg::CTRL_RUN_REQ];
  wire halt_req = wr_ctrl & DAT_I[pds_pkg::CTRL_HALT];
  wire refused = run_req & ~RUN & (|up_block);
  assign ev_set[pds_pkg::EV_REFUSED] = refused;

  // Run latch: a fault always wins over an entry request
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RUN <= 1'b0;
    end else if (any_fault | halt_req) begin
      RUN <= 1'b0;
    end else if (run_req & ~(|up_block)) begin
      RUN <= 1'b1;
    end
  end

  // Quadrature decode: one step when exactly one line changed
  wire [1:0] enc_now = {ENC_A, ENC_B};
  wire enc_step = ^(enc_now ^ enc_prev);
  wire enc_fwd = enc_prev[1] ^ enc_now[0];

  // Edge count and length, each edge worth one resolution step
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      enc_prev <= 2'b00;
      edges <= 32'h0000_0000;
      length <= 32'h0000_0000;
    end else begin
      enc_prev <= enc_now;
      if (enc_step) begin
        edges <= enc_fwd ? edges + 32'h0000_0001 : edges - 32'h0000_0001;
        length <= enc_fwd ? length + resol : length - resol;
      end
    end
  end

  // Software settings; resolution must be loaded before use
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      resol <= 32'h0000_0000;
      enc_cnt <= 30'h0000_0000;
      int_mask <= 32'h0000_0000;
    end else begin
      if (wr_resol) begin
        resol <= DAT_I;
      end
      if (wr_enc_cnt) begin
        enc_cnt <= DAT_I[29:0];
      end
      if (wr_imask) begin
        int_mask <= DAT_I;
      end
    end
  end

  // Status and mask as they stand after this edge
  wire [31:0] clr_bits = wr_istat ? DAT_I : 32'h0000_0000; // Bits software clears now
  wire [31:0] next_stat = (int_stat & ~clr_bits) | ev_set; // Set wins over clear
  wire [31:0] next_mask = wr_imask ? DAT_I : int_mask; // A mask write counts at once

  // Sticky events; IRQ follows the new mask with no extra cycle of lag
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_stat <= 32'h0000_0000;
      IRQ <= 1'b0;
    end else begin
      int_stat <= next_stat;
      IRQ <= |(next_stat & next_mask);
    end
  end

  // Read selection
  logic [31:0] ch_pick;
  always_comb begin
    ch_pick = 32'h0000_0000;
    for (int j = 0; j < NCH; j++) begin
      if (ch_hit[j]) begin
        ch_pick = ch_rd[j];
      end
    end
  end
  wire [NCH-1:0] busy;
  for (genvar b = 0; b < NCH; b++) begin : g_busy
    assign busy[b] = (st[b] != pds_pkg::PDS_IDLE);
  end
  wire [31:0] status_rd = {15'h0000, 8'(up_block), 8'(busy), RUN};
  wire [31:0] pulses_rd = {enc_cnt, 2'b00}; // Rated counts times 4
  wire [31:0] rd_mux =
    (ADR_I == pds_pkg::OFS_CTRL) ? 32'h0000_0000 :
    (ADR_I == pds_pkg::OFS_STATUS) ? status_rd :
    (ADR_I == pds_pkg::OFS_INT_STAT) ? int_stat :
    (ADR_I == pds_pkg::OFS_INT_MASK) ? int_mask :
    (ADR_I == pds_pkg::OFS_RESOL) ? resol :
    (ADR_I == pds_pkg::OFS_LENGTH) ? length :
    (ADR_I == pds_pkg::OFS_EDGES) ? edges :
    (ADR_I == pds_pkg::OFS_ENC_CNT) ? {2'b00, enc_cnt} :
    (ADR_I == pds_pkg::OFS_PULSES_REV) ? pulses_rd : ch_pick;

  // Bus answer: one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= bus_req & ~ACK_O;
      if (bus_req & ~ACK_O) begin
        DAT_O <= rd_mux;
      end
    end
  end

endmodule

// *** verilog/pds_pkg.sv ***
// Package of offsets, field positions, reset values and timing for the dwell sequencer
package pds_pkg;
  // Clock period and dwell unit, both in nanoseconds
  localparam int CLK_PERIOD_NS = 4;
  localparam int DWELL_LSB_NS = 1_000_000;
  // Cycles in one dwell unit (1 ms): a least time, so rounded up
  localparam int TICK_CYCLES = (DWELL_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Dwell limits in ms units
  localparam logic [14:0] DWELL_MAX = 15'h7530;
  localparam logic [14:0] DWELL_DN_MIN = 15'h0001;
  localparam logic [14:0] DWELL_UP_MIN = 15'h0000;
  // Reset dwell values, 125 ms each
  localparam logic [14:0] DWELL_RST = 15'h007D;
  // Quadrature edges per encoder rated count
  localparam int EDGES_PER_COUNT = 4;
  // Global register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_RESOL = 8'h10;
  localparam logic [7:0] OFS_LENGTH = 8'h14;
  localparam logic [7:0] OFS_EDGES = 8'h18;
  localparam logic [7:0] OFS_ENC_CNT = 8'h1C;
  localparam logic [7:0] OFS_PULSES_REV = 8'h20;
  // Channel blocks: base, stride 16 bytes, word offsets inside a block
  localparam logic [3:0] CH_BASE_IDX = 4'h4;
  localparam logic [1:0] CH_DWELL_DN = 2'h0;
  localparam logic [1:0] CH_DWELL_UP = 2'h1;
  localparam logic [1:0] CH_CFG = 2'h2;
  localparam logic [1:0] CH_STATE = 2'h3;
  // Control bits
  localparam int CTRL_RUN_REQ = 0;
  localparam int CTRL_HALT = 1;
  // Channel config bits
  localparam int CFG_EXP_DN = 0;
  localparam int CFG_EXP_UP = 1;
  localparam int CFG_FIRE = 2;
  // Interrupt layout: per channel three bits, then the refusal bit at 24
  localparam int EV_PER_CH = 3;
  localparam int EV_FAULT_DN = 0;
  localparam int EV_FAULT_UP = 1;
  localparam int EV_DONE = 2;
  localparam int EV_REFUSED = 24;
  // Channel sequence states
  typedef enum logic [1:0] {
    PDS_IDLE = 2'b00,
    PDS_DOWN = 2'b01,
    PDS_UP = 2'b10
  } pds_state_t;
endpackage

// *** tb/pds_props.sv ***
// Port-level checker of the dwell sequencer
module pds_props #(
  parameter int NCH = 3,
  parameter int TICK_CYCLES = 10
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [NCH-1:0] FIRE,
  input wire logic [NCH-1:0] CMP_DN,
  input wire logic [NCH-1:0] CMP_UP,
  input wire logic [NCH-1:0] OUT_DN,
  input wire logic [NCH-1:0] OUT_UP
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one clocking and one disable for all
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_dn_cut: assert property (OUT_DN[0] && CMP_DN[0] |=> !OUT_DN[0])
    else $error("shear down held after completion");
  a_up_cut: assert property (OUT_UP[0] && CMP_UP[0] |=> !OUT_UP[0])
    else $error("shear up held after completion");
  a_press_cut: assert property (OUT_DN[1] && CMP_DN[1] |=> !OUT_DN[1])
    else $error("press down held after completion");
  a_press_up_cut: assert property (OUT_UP[1] && CMP_UP[1] |=> !OUT_UP[1])
    else $error("press up held after completion");
  a_up_after_dn: assert property ($rose(OUT_UP[0]) |-> $fell(OUT_DN[0]))
    else $error("shear up began without down ending");
  a_press_order: assert property ($rose(OUT_UP[1]) |-> $fell(OUT_DN[1]))
    else $error("press up began without down ending");
  a_fire_start: assert property (
    $rose(FIRE[0]) && !OUT_DN[0] && !OUT_UP[0] |=> OUT_DN[0] && !OUT_UP[0])
    else $error("fire did not start the shear down phase");
  a_press_start: assert property (
    $rose(FIRE[1]) && !OUT_DN[1] && !OUT_UP[1] |=>
    OUT_DN[1] ##1 (OUT_DN[1] || $past(CMP_DN[1])))
    else $error("fire did not start the press down phase");
endmodule
bind pds_sequencer pds_props #(.NCH(NCH), .TICK_CYCLES(TICK_CYCLES)) i_pds_props (
  .CLK(CLK), .RSTN(RSTN), .FIRE(FIRE), .CMP_DN(CMP_DN),
  .CMP_UP(CMP_UP), .OUT_DN(OUT_DN), .OUT_UP(OUT_UP));

// *** tb/pds_far_model.sv ***
// Press solenoids with their down and home completion switches
module pds_far_model #(
  parameter int NCH = 3
) (
  input wire logic clk,
  input wire logic [NCH-1:0] out_dn,
  input wire logic [NCH-1:0] out_up,
  input wire logic [NCH-1:0] dn_ok,
  input wire logic [NCH-1:0] up_ok,
  input wire logic [7:0] lat,
  output logic [NCH-1:0] cmp_dn,
  output logic [NCH-1:0] cmp_up
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stroke timers; the down switch stays made until the up output drops
  logic [7:0] t_dn [NCH];
  logic [7:0] t_up [NCH];
  always @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      t_dn[i] <= out_dn[i] ? t_dn[i] + 8'h01 : (out_up[i] ? t_dn[i] : 8'h00);
      t_up[i] <= out_up[i] ? t_up[i] + 8'h01 : 8'h00;
    end
  end
  // A broken switch never makes; a slow press needs lat cycles of stroke
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cmp_dn[i] = dn_ok[i] && (out_dn[i] || out_up[i]) && t_dn[i] >= lat;
      cmp_up[i] = up_ok[i] && !out_dn[i] && !(out_up[i] && t_up[i] < lat);
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the press dwell sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 3;
  localparam int TK = 10;
  // Every design input driven by the bench has a value at time zero; CMP_DN and CMP_UP from the model follow OUT_DN and OUT_UP
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic enc_a = 1'b0, enc_b = 1'b0, ack, run, irq;
  logic [7:0] adr = 8'h00, lat = 8'h03;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, rq;
  logic [NCH-1:0] fire = '0, dn_ok = '1, up_ok = '1, cmp_dn, cmp_up, out_dn, out_up;
  int n_fail = 0, n_tests = 0, nd, nu;
  always #2 clk = ~clk;
  pds_sequencer #(.NCH(NCH), .TICK_CYCLES(TK)) i_pds_sequencer (
    .CLK(clk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .FIRE(fire),
    .CMP_DN(cmp_dn), .CMP_UP(cmp_up), .ENC_A(enc_a), .ENC_B(enc_b),
    .OUT_DN(out_dn), .OUT_UP(out_up), .RUN(run), .IRQ(irq));
  pds_far_model #(.NCH(NCH)) i_pds_far_model (
    .clk(clk), .out_dn(out_dn), .out_up(out_up), .dn_ok(dn_ok), .up_ok(up_ok),
    .lat(lat), .cmp_dn(cmp_dn), .cmp_up(cmp_up));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Compare; a hang check that fails ends the run at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      if (nm == "hang") wrap_up();
    end
  endtask
  // Classic cycle held until ack, then one idle cycle; read data lands in rq
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {cyc, stb, we, adr, sel, dat_w} <= {2'h3, w, a, 4'hF, d};
    for (k = 0; k < 20 && ack !== 1'b1; k++) begin
      @(posedge clk);
    end
    chk("hang", 1, k < 20);
    rq = dat_r;
    {cyc, stb, sel} <= 6'h00;
    @(posedge clk);
  endtask
  function automatic logic [7:0] ca(input int c, input logic [7:0] o);
    return 8'h40 + 8'(c * 16) + o;
  endfunction
  // Fire a channel and count the cycles each phase output stands
  task automatic cycle(input int c);
    int k;
    nd = 0;
    nu = 0;
    fire[c] <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      nd += int'(out_dn[c] === 1'b1);
      nu += int'(out_up[c] === 1'b1);
      if (out_dn[c] !== 1'b1 && out_up[c] !== 1'b1) break;
    end
    chk("hang", 1, k < 200);
    fire[c] <= 1'b0;
    @(posedge clk);
  endtask
  // Reset value, unmapped space, the dwell floor, then short dwells
  task automatic t_regs();
    wb(1'b0, ca(0, 8'h00), 32'h0);
    chk("dn_reset", 32'h7D, rq);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rq);
    wb(1'b1, ca(2, 8'h00), 32'h0);
    wb(1'b0, ca(2, 8'h00), 32'h0);
    chk("dn_floor", 32'h1, rq);
    for (int c = 0; c < NCH; c++) begin
      wb(1'b1, ca(c, 8'h00), 32'h2);
      wb(1'b1, ca(c, 8'h04), 32'h1);
    end
  endtask
  // Resolution goes in first, then four forward edges and one back
  task automatic t_enc();
    logic [1:0] s [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2};
    wb(1'b1, 8'h10, 32'h5);
    wb(1'b1, 8'h1C, 32'h100);
    wb(1'b0, 8'h20, 32'h0);
    chk("pulses_per_revolution", 32'h400, rq);
    foreach (s[i]) begin
      {enc_a, enc_b} <= s[i];
      repeat (2) @(posedge clk);
    end
    wb(1'b0, 8'h14, 32'h0);
    chk("length", 32'hF, rq);
    wb(1'b0, 8'h18, 32'h0);
    chk("edges", 32'h3, rq);
  endtask
  // Full dwells, completion cuts, and the done interrupt behind its mask
  task automatic t_timing();
    lat <= 8'h28;
    cycle(0);
    chk("dn_full", 2 * TK, nd);
    chk("up_full", TK, nu);
    lat <= 8'h03;
    up_ok <= '0;
    cycle(1);
    chk("press_cut", 1, nd < 2 * TK);
    chk("up_ignores_dn", TK, nu);
    up_ok <= '1;
    wb(1'b1, 8'h08, 32'hFFFF_FFFF);
    wb(1'b1, 8'h0C, 32'h4);
    for (int c = 0; c < 2; c++) begin
      cycle(c);
      chk("dn_cut", 1, nd < 2 * TK);
      chk("up_cut", 1, nu < TK && nu > 0);
    end
    chk("irq_set", 1, irq);
    wb(1'b1, 8'h08, 32'h4);
    chk("irq_clear", 0, irq);
    wb(1'b1, 8'h0C, 32'h20);
    chk("irq_mask", 1, irq);
  endtask
  // A missing down completion aborts, missing completions leave run; an open home switch blocks run
  task automatic t_faults();
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, 8'h08, 32'hFFFF_FFFF);
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b1, ca(c, 8'h08), 32'h1);
      chk("run_on", 1, run);
      dn_ok[c] <= 1'b0;
      cycle(c);
      dn_ok[c] <= 1'b1;
      chk("dn_fault_noup", 0, nu);
      wb(1'b0, 8'h08, 32'h0);
      chk("dn_fault", 1, rq[3 * c]);
      chk("dn_fault_run", 0, run);
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b1, ca(c, 8'h08), 32'h2);
      lat <= 8'h28;
      cycle(c);
      lat <= 8'h03;
      chk("up_fault_len", TK, nu);
      wb(1'b0, 8'h08, 32'h0);
      chk("up_fault", 1, rq[3 * c + 1]);
      chk("up_fault_run", 0, run);
      up_ok[c] <= 1'b0;
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b0, 8'h08, 32'h0);
      chk("refused", 1, rq[24]);
      chk("refused_run", 0, run);
      up_ok[c] <= 1'b1;
      wb(1'b1, ca(c, 8'h08), 32'h0);
    end
  endtask
  // Run with status readback, halt, then a cycle started from software
  task automatic t_soft();
    int k;
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h1, rq);
    wb(1'b1, 8'h00, 32'h2);
    chk("halt", 0, run);
    wb(1'b1, ca(2, 8'h08), 32'h4);
    chk("soft_fire", 1, out_dn[2]);
    for (k = 0; k < 200 && (out_dn[2] | out_up[2]) !== 1'b0; k++) begin
      @(posedge clk);
    end
    chk("hang", 1, k < 200);
    wb(1'b0, 8'h08, 32'h0);
    chk("soft_done", 1, rq[8]);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enc();
    t_timing();
    t_faults();
    t_soft();
    wrap_up();
  end
endmodule
